// >>> sfcu_defs.svh
// sfcu_defs.svh: encodings and field positions of the set-flag compare unit
// assumes: included by bare name from the package and the unit files
`ifndef SFCU_DEFS_SVH
`define SFCU_DEFS_SVH

// ------------------------------------------------------------
// instruction fields
// ------------------------------------------------------------
`define SFCU_OPC_HI    31
`define SFCU_OPC_LO    21
`define SFCU_SRC1_HI   20
`define SFCU_SRC1_LO   16
`define SFCU_SRC2_HI   15
`define SFCU_SRC2_LO   11
`define SFCU_IMM_HI    15
`define SFCU_IMM_LO    0
`define SFCU_IMM_W     16

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define SFCU_OPC_GES   11'h72b
`define SFCU_OPC_GESI  11'h5eb
`define SFCU_OPC_GEU   11'h723
`define SFCU_OPC_GEUI  11'h5e3
`define SFCU_OPC_GTS   11'h72a
`define SFCU_OPC_GTSI  11'h5ea
`define SFCU_OPC_GTU   11'h722
`define SFCU_OPC_GTUI  11'h5e2
`define SFCU_OPC_LES   11'h72d
`define SFCU_OPC_LESI  11'h5ed
`define SFCU_OPC_LEU   11'h725

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SFCU_FLAG_RST  1'b0

`endif

// >>> sfcu_pkg.sv
// sfcu_pkg.sv: types of the set-flag compare unit
// assumes: sfcu_defs.svh is on the include path
`default_nettype none
`include "sfcu_defs.svh"

package sfcu_pkg;
  // ------------------------------------------------------------
  // relation and decode result
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SFCU_REL_GE = 2'h0,
    SFCU_REL_GT = 2'h1,
    SFCU_REL_LE = 2'h2
  } sfcu_rel_t;

  typedef struct packed {
    logic      hit;
    logic      is_imm;
    logic      is_signed;
    sfcu_rel_t rel;
  } sfcu_dec_t;
endpackage

`default_nettype wire

// >>> sfcu_cmp.sv
// sfcu_cmp.sv: combinational magnitude comparator for one relation
// assumes: operands already sized and extended by the caller
`default_nettype none
`include "sfcu_defs.svh"

module sfcu_cmp #(
  parameter int unsigned WIDTH = 32
) (
  // operands
  input  wire logic [WIDTH-1:0] a_i,
  input  wire logic [WIDTH-1:0] b_i,
  // selection
  input  wire logic             is_signed_i,
  input  wire sfcu_pkg::sfcu_rel_t rel_i,
  // result
  output logic                  holds_o
);
  import sfcu_pkg::*;

  logic lt;
  logic eq;

  // flip the sign bits so one unsigned compare serves both kinds
  always_comb begin
    eq = (a_i == b_i);
    if (is_signed_i) begin
      lt = ({~a_i[WIDTH-1], a_i[WIDTH-2:0]} < {~b_i[WIDTH-1], b_i[WIDTH-2:0]});
    end else begin
      lt = (a_i < b_i);
    end
  end

  // pick the relation; a false result clears the flag
  always_comb begin
    unique case (rel_i)
      SFCU_REL_GE: holds_o = ~lt;
      SFCU_REL_GT: holds_o = ~lt & ~eq;
      SFCU_REL_LE: holds_o = lt | eq;
      default:     holds_o = 1'b0;
    endcase
  end
endmodule

`default_nettype wire

// >>> sfcu_top.sv
// sfcu_top.sv: decode and flag update for the greater/less set-flag compares
// assumes: register file reads both sources combinationally from the indices
//   that this unit puts out; operands on source_one_gpr_i and source_two_gpr_i in the cycle insn_valid_i
//   is high; the flag result goes to the compare bit of supervision_register.
//
// Function
// - reg-reg form: opcode 31:21, first source 20:16, second source 15:11.
// - immediate form: opcode 31:21, source 20:16, immediate 15:0 sign-extended.
// - every compare writes the flag: set if relation holds, else cleared.
// - opcode 0x72b: first >= second, signed.
// - opcode 0x5eb: source >= extended immediate, signed.
// - opcode 0x723: first >= second, unsigned.
// - opcode 0x5e3: source >= sign-extended immediate, unsigned.
// - opcode 0x72a: first > second, signed.
// - opcode 0x5ea: source > extended immediate, signed.
// - opcode 0x722: first > second, unsigned.
// - opcode 0x5e2: source > sign-extended immediate, unsigned.
// - opcode 0x72d: first <= second, signed.
// - opcode 0x5ed: source <= extended immediate, signed.
// - opcode 0x725: first <= second, unsigned.
// - compare full 32 or 64 bits; no compare raises an exception.
`default_nettype none
`include "sfcu_defs.svh"

module sfcu_top #(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // instruction
  input  wire logic             insn_valid_i,
  input  wire logic [31:0]      insn_i,
  // register file read ports
  output logic [4:0]            source_one_idx_o,
  output logic [4:0]            source_two_idx_o,
  input  wire logic [WIDTH-1:0] source_one_gpr_i,
  input  wire logic [WIDTH-1:0] source_two_gpr_i,
  // supervision_register compare bit, hit and exception lines
  output logic                  flag_we_o,
  output logic                  flag_o,
  output logic                  hit_o,
  output logic                  exception_o
);
  import sfcu_pkg::*;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------

  // table decode; bits 10:0 of reg-reg forms never reach it
  function automatic sfcu_dec_t sfcu_decode(input logic [10:0] opc);
    sfcu_dec_t d;
    d = '{hit: 1'b1, is_imm: 1'b0, is_signed: 1'b0, rel: SFCU_REL_GE};
    unique case (opc)
      `SFCU_OPC_GES:  begin d.is_signed = 1'b1; d.rel = SFCU_REL_GE; end
      `SFCU_OPC_GESI: begin d.is_imm = 1'b1; d.is_signed = 1'b1; end
      `SFCU_OPC_GEU:  d.rel = SFCU_REL_GE;
      `SFCU_OPC_GEUI: d.is_imm = 1'b1;
      `SFCU_OPC_GTS:  begin d.is_signed = 1'b1; d.rel = SFCU_REL_GT; end
      `SFCU_OPC_GTSI: begin
        d.is_imm = 1'b1;
        d.is_signed = 1'b1;
        d.rel = SFCU_REL_GT;
      end
      `SFCU_OPC_GTU:  d.rel = SFCU_REL_GT;
      `SFCU_OPC_GTUI: begin d.is_imm = 1'b1; d.rel = SFCU_REL_GT; end
      `SFCU_OPC_LES:  begin d.is_signed = 1'b1; d.rel = SFCU_REL_LE; end
      `SFCU_OPC_LESI: begin
        d.is_imm = 1'b1;
        d.is_signed = 1'b1;
        d.rel = SFCU_REL_LE;
      end
      `SFCU_OPC_LEU:  d.rel = SFCU_REL_LE;
      default:        d.hit = 1'b0;
    endcase
    return d;
  endfunction

  sfcu_dec_t        dec;
  logic [10:0]      opc;
  logic [WIDTH-1:0] imm_ext;
  logic [WIDTH-1:0] operand_b;
  logic             holds;

  // field split; low 11 bits only feed the immediate path
  assign opc = insn_i[`SFCU_OPC_HI:`SFCU_OPC_LO];
  assign dec = sfcu_decode(opc);
  assign imm_ext = {{(WIDTH-`SFCU_IMM_W){insn_i[`SFCU_IMM_HI]}},
                    insn_i[`SFCU_IMM_HI:`SFCU_IMM_LO]};
  assign operand_b = dec.is_imm ? imm_ext : source_two_gpr_i;

  // ------------------------------------------------------------
  // compare over the full operand width
  // ------------------------------------------------------------

  sfcu_cmp #(
    .WIDTH       (WIDTH)
  ) u_cmp (
    .a_i         (source_one_gpr_i),
    .b_i         (operand_b),
    .is_signed_i (dec.is_signed),
    .rel_i       (dec.rel),
    .holds_o     (holds)
  );

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------

  // read indices mirror the instruction fields, one cycle late
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      source_one_idx_o <= 5'h0;
      source_two_idx_o <= 5'h0;
    end else begin
      source_one_idx_o <= insn_i[`SFCU_SRC1_HI:`SFCU_SRC1_LO];
      source_two_idx_o <= insn_i[`SFCU_SRC2_HI:`SFCU_SRC2_LO];
    end
  end

  // flag write: every decoded compare writes, true sets, false clears
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_we_o <= 1'b0;
      hit_o     <= 1'b0;
      flag_o    <= `SFCU_FLAG_RST;
    end else begin
      flag_we_o <= insn_valid_i & dec.hit;
      hit_o     <= insn_valid_i & dec.hit;
      if (insn_valid_i && dec.hit) begin
        flag_o <= holds;
      end
    end
  end

  // these compares never trap, so the line is held low by a register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exception_o <= 1'b0;
    end else begin
      exception_o <= 1'b0;
    end
  end
endmodule

`default_nettype wire

// >>> sfcu_top_asserts.sv
// sfcu_top_asserts.sv: port checks of the set-flag compare unit
// assumes: bound into every sfcu_top, one clock domain
`default_nettype none
module sfcu_top_asserts #(
  parameter int unsigned WIDTH = 32
) (
  input wire logic             sys_clk_i,
  input wire logic             rst_n_i,
  input wire logic             insn_valid_i,
  input wire logic [31:0]      insn_i,
  input wire logic [4:0]       source_one_idx_o,
  input wire logic [4:0]       source_two_idx_o,
  input wire logic [WIDTH-1:0] source_one_gpr_i,
  input wire logic [WIDTH-1:0] source_two_gpr_i,
  input wire logic             flag_we_o,
  input wire logic             flag_o,
  input wire logic             hit_o,
  input wire logic             exception_o
);
  // ----
  // reference relation, built from opcode bits rather than a table
  // ----
  logic [10:0]      op;
  logic [WIDTH-1:0] b;
  logic             take, gt, want;
  assign op = insn_i[31:21];
  assign take = insn_valid_i && (op inside {11'h72b, 11'h5eb, 11'h723, 11'h5e3, 11'h72a,
                11'h5ea, 11'h722, 11'h5e2, 11'h72d, 11'h5ed, 11'h725});
  assign b = op[9] ? source_two_gpr_i : {{(WIDTH-16){insn_i[15]}}, insn_i[15:0]};
  assign gt = op[3] ? $signed(source_one_gpr_i) > $signed(b) : source_one_gpr_i > b;
  assign want = op[2] ? !gt : gt | (op[0] & (source_one_gpr_i == b));
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take;
    take;
  endsequence
  sequence s_idle;
    !take;
  endsequence
  we_pulse_a: assert property (s_take |=> flag_we_o) else $error("flag write missing");
  no_write_a: assert property (s_idle |=> !flag_we_o && $stable(flag_o))
    else $error("flag changed without compare");
  reg_value_a: assert property (s_take ##0 op[9] |=> flag_o == $past(want))
    else $error("register compare result wrong");
  imm_value_a: assert property (s_take ##0 !op[9] |=> flag_o == $past(want))
    else $error("immediate compare result wrong");
  hit_match_a: assert property (hit_o == flag_we_o) else $error("hit differs from write");
  no_exc_a: assert property (!exception_o) else $error("exception raised");
  idx_one_a: assert property (##1 source_one_idx_o == $past(insn_i[20:16]))
    else $error("first index wrong");
  idx_two_a: assert property (##1 source_two_idx_o == $past(insn_i[15:11]))
    else $error("second index wrong");
endmodule
bind sfcu_top sfcu_top_asserts #(.WIDTH(WIDTH)) u_sfcu_top_asserts (.sys_clk_i, .rst_n_i,
  .insn_valid_i, .insn_i, .source_one_idx_o, .source_two_idx_o, .source_one_gpr_i,
  .source_two_gpr_i, .flag_we_o, .flag_o, .hit_o, .exception_o);
`default_nettype wire

// >>> sfcu_top_tb_top.sv
// sfcu_top_tb_top.sv: self-checking bench of the set-flag compare unit
// assumes: 32-bit operands, inputs driven on the falling edge
`default_nettype none
module sfcu_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 0, rst_n_i = 0, insn_valid_i = 0, ef = 0;
  logic        flag_we_o, flag_o, hit_o, exception_o;
  logic [31:0] insn_i = '0, source_one_gpr_i = '0, source_two_gpr_i = '0;
  logic [4:0]  source_one_idx_o, source_two_idx_o;
  int          fails = 0, n_tests = 0;
  // ----
  // operand tables: equality, sign boundary and all-ones cases
  // ----
  logic [10:0] rop [6] = '{11'h72b, 11'h723, 11'h72a, 11'h722, 11'h72d, 11'h725};
  logic [10:0] iop [5] = '{11'h5eb, 11'h5e3, 11'h5ea, 11'h5e2, 11'h5ed};
  logic [31:0] pa [5] = '{5, 3, 7, 32'h80000000, 32'hffffffff};
  logic [31:0] pb [5] = '{3, 5, 7, 32'h7fffffff, 1};
  logic [31:0] qa [5] = '{5, 32'hffffffff, 32'h80000000, 3, 32'h0000ffff};
  logic [15:0] qi [5] = '{16'h0003, 16'hffff, 16'h8000, 16'hffff, 16'hffff};
  always #12.5 sys_clk_i = ~sys_clk_i;
  sfcu_top #(.WIDTH(32)) u_sfcu_top (.sys_clk_i, .rst_n_i, .insn_valid_i, .insn_i,
    .source_one_idx_o, .source_two_idx_o, .source_one_gpr_i, .source_two_gpr_i,
    .flag_we_o, .flag_o, .hit_o, .exception_o);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // {written, value}; a foreign opcode keeps the old flag
  function automatic logic [1:0] want(input logic [10:0] o, input logic [31:0] a, b);
    case (o)
      11'h72b, 11'h5eb: want = {1'b1, $signed(a) >= $signed(b)};
      11'h723, 11'h5e3: want = {1'b1, a >= b};
      11'h72a, 11'h5ea: want = {1'b1, $signed(a) > $signed(b)};
      11'h722, 11'h5e2: want = {1'b1, a > b};
      11'h72d, 11'h5ed: want = {1'b1, $signed(a) <= $signed(b)};
      11'h725: want = {1'b1, a <= b};
      default: want = {1'b0, ef};
    endcase
  endfunction
  // one instruction; left asserted so the next call runs back to back
  task automatic op(input logic v, input logic [10:0] o, input logic [31:0] a, b,
                    input logic [15:0] lo);
    logic [1:0] r;
    r = want(o, a, o[9] ? b : {{16{lo[15]}}, lo});
    if (!v) r = {1'b0, ef};
    insn_valid_i = v;
    insn_i = {o, 5'h0b, lo};
    source_one_gpr_i = a;
    source_two_gpr_i = b;
    @(negedge sys_clk_i);
    ef = r[0];
    chk("flag_we_o", r[1], flag_we_o);
    chk("hit_o", r[1], hit_o);
    chk("flag_o", ef, flag_o);
    chk("exception_o", 0, exception_o);
    chk("source_one_idx_o", 5'h0b, source_one_idx_o);
    chk("source_two_idx_o", lo[15:11], source_two_idx_o);
  endtask
  task automatic t_regreg();
    foreach (rop[i]) foreach (pa[j])
      op(1, rop[i], pa[j], pb[j], 16'h1fff);
  endtask
  task automatic t_imm();
    foreach (iop[i]) foreach (qa[j])
      op(1, iop[i], qa[j], ~qa[j], qi[j]);
  endtask
  task automatic t_refuse();
    op(1, 11'h72b, 5, 3, 16'h1800);
    op(0, 11'h72a, 0, 1, 16'h1800);
    op(1, 11'h720, 0, 1, 16'h1800);
    op(1, 11'h724, 0, 1, 16'h1800);
  endtask
  initial begin
    repeat (4) @(negedge sys_clk_i);
    rst_n_i = 1;
    repeat (2) @(negedge sys_clk_i);
    t_refuse();
    t_regreg();
    t_imm();
    final_report();
  end
  initial begin
    #(25 * 1000);
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
